//--- hdl/tsf_framer.sv
/*
  One end of the time-slot-0 framer: transmit and receive.
  Assumes both ends are aligned from reset over the link interface;
  frame alignment search is outside this block.
*/
// Contract
// - Frames are 256 bits at 8 kHz; code takes 9 clocks a bit at 20 MHz, near 8.68 kHz
// - Alternate frames send alignment word 0011011
// - Non-alignment frames hold bit 2 at one
// - Bit 3 carries remote alarm flag
// - Spare bits 4 to 8 sent as ones
// - Sixteen frames form two eight-frame halves
// - Check bits in even frames bit 1
// - Odd frames 1 to 11 carry 001011
// - Frames 13, 15 carry error indications
// - Each faulty half clears one outgoing E
// - Received E bits always used
// - Check bits are previous half's remainder
// - First bit most significant; check_bit_first MSB
// - Check-bit positions counted as zeros
// - Stored remainder compared with next half
// - Overhead occupies time slot 0
`timescale 1ns/10ps
`include "tsf_defs.svh"
module tsf_framer (
  // Clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                NRST_I,
  // Link
  tsf_link_if.near_end             link,
  // Payload in (time slots 1..31)
  input  wire logic                TX_VALID_I,
  output logic                     TX_READY_O,
  input  wire tsf_pkg::tsf_octet_t TX_DATA_I,
  // Control
  input  wire logic                ALARM_I,
  // Payload out
  output logic                     RX_VALID_O,
  output tsf_pkg::tsf_octet_t      RX_DATA_O,
  // Status
  output logic                     RX_ALARM_O,
  output logic [1:0]               RX_E_BITS_O,
  output logic                     RX_CRC_FAIL_O
);
  import tsf_pkg::*;

  localparam int BITDIV = `TSF_BIT_CYCLES;

  // ---------------------------------------------------------------
  // Bit clock strobe
  // ---------------------------------------------------------------
  logic [7:0]     div_cnt;
  logic           bit_stb;
  tsf_bit_idx_t   tx_bit;
  tsf_frame_idx_t tx_frm;
  tsf_crc_t       tx_crc;
  tsf_crc_t       tx_send;
  logic [1:0]     e_pend;
  logic [1:0]     e_out;
  logic           tx_bit_val;
  tsf_octet_t     tx_shift;
  logic           fifo_valid;
  logic           fifo_take;
  tsf_octet_t     fifo_data;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= (div_cnt == 8'(BITDIV - 1)) ? 8'h00 : div_cnt + 8'h01;
    end
  end
  assign bit_stb = (div_cnt == 8'(BITDIV - 1));

  // ---------------------------------------------------------------
  // Transmit counters
  // ---------------------------------------------------------------
  // bit index 0..255 stands for bit 1..256
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_bit <= 8'h00;
      tx_frm <= 4'h0;
    end else if (bit_stb) begin
      tx_bit <= tx_bit + 8'h01;
      if (tx_bit == 8'hFF) begin
        tx_frm <= tx_frm + 4'h1;
      end
    end
  end

  // Payload buffered so an empty source just sends idle ones
  tsf_fifo #(.WIDTH(8), .DEPTH(`TSF_FIFO_DEPTH)) u_tx_fifo (
    .clk_i       (REF_CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (TX_VALID_I),
    .in_ready_o  (TX_READY_O),
    .in_data_i   (TX_DATA_I),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take),
    .out_data_o  (fifo_data)
  );
  assign fifo_take = bit_stb && (tx_bit[2:0] == 3'h7) && (tx_bit[7:3] != 5'h1F) && fifo_valid;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_shift <= 8'hFF;
    end else if (bit_stb && tx_bit[2:0] == 3'h7) begin
      // Next slot's octet; slot 0 wraps to overhead
      tx_shift <= (tx_bit[7:3] != 5'h1F && fifo_valid) ? fifo_data : 8'hFF;
    end else if (bit_stb) begin
      tx_shift <= {tx_shift[6:0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // Time-slot-0 overhead
  // ---------------------------------------------------------------
  logic [6:0] aw;
  logic [4:0] spare;
  logic [5:0] mfp;
  assign aw    = `TSF_ALIGN_WORD;
  assign spare = `TSF_SPARE_ONES;
  assign mfp   = `TSF_MF_PATTERN;

  always_comb begin
    tx_bit_val = tx_shift[7];
    if (tx_bit[7:3] == 5'h00) begin
      if (tx_bit[2:0] == 3'h0) begin
        if (!tx_frm[0]) begin
          tx_bit_val = tx_send[3 - tx_frm[2:1]];
        end else if (tx_frm == 4'hD) begin
          tx_bit_val = e_out[1];
        end else if (tx_frm == 4'hF) begin
          tx_bit_val = e_out[0];
        end else begin
          tx_bit_val = mfp[5 - tx_frm[3:1]];
        end
      end else if (!tx_frm[0]) begin
        tx_bit_val = aw[7 - tx_bit[2:0]];
      end else if (tx_bit[2:0] == 3'h1) begin
        tx_bit_val = 1'b1;
      end else if (tx_bit[2:0] == 3'h2) begin
        tx_bit_val = ALARM_I;
      end else begin
        tx_bit_val = spare[7 - tx_bit[2:0]];
      end
    end
  end

  // CRC over the half with check-bit slots as zero
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_crc  <= 4'h0;
      tx_send <= 4'h0;
    end else if (bit_stb) begin
      if (tx_bit == 8'hFF && tx_frm[2:0] == 3'h7) begin
        tx_send <= tsf_crc_step(tx_crc, tx_bit_val);
        tx_crc  <= 4'h0;
      end else if (tx_bit == 8'h00 && !tx_frm[0]) begin
        tx_crc <= tsf_crc_step(tx_crc, 1'b0);
      end else begin
        tx_crc <= tsf_crc_step(tx_crc, tx_bit_val);
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      link.a_data   <= 1'b1;
      link.a_strobe <= 1'b0;
    end else begin
      link.a_strobe <= bit_stb;
      if (bit_stb) begin
        link.a_data <= tx_bit_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive side, aligned to the peer from reset
  // ---------------------------------------------------------------
  tsf_bit_idx_t   rx_bit;
  tsf_frame_idx_t rx_frm;
  tsf_crc_t       rx_crc;
  tsf_crc_t       rx_stored;
  tsf_crc_t       rx_cbits;
  logic           rx_checked;
  logic           rx_fail;
  tsf_octet_t     rx_shift;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_bit <= 8'h00;
      rx_frm <= 4'h0;
    end else if (link.b_strobe) begin
      rx_bit <= rx_bit + 8'h01;
      if (rx_bit == 8'hFF) begin
        rx_frm <= rx_frm + 4'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_crc     <= 4'h0;
      rx_stored  <= 4'h0;
      rx_cbits   <= 4'h0;
      rx_checked <= 1'b0;
    end else if (link.b_strobe) begin
      if (rx_bit == 8'h00 && !rx_frm[0]) begin
        rx_cbits[3 - rx_frm[2:1]] <= link.b_data;
        rx_crc <= tsf_crc_step(rx_crc, 1'b0);
      end else if (rx_bit == 8'hFF && rx_frm[2:0] == 3'h7) begin
        rx_stored  <= tsf_crc_step(rx_crc, link.b_data);
        rx_crc     <= 4'h0;
        rx_checked <= 1'b1;
      end else begin
        rx_crc <= tsf_crc_step(rx_crc, link.b_data);
      end
    end
  end

  // Check fires at end of half, once all four check bits are in
  assign rx_fail = link.b_strobe && rx_checked && (rx_bit == 8'hFF) && (rx_frm[2:0] == 3'h7)
                   && (rx_cbits != rx_stored);

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RX_CRC_FAIL_O <= 1'b0;
      RX_ALARM_O    <= 1'b0;
      RX_E_BITS_O   <= 2'h3;
      RX_VALID_O    <= 1'b0;
      RX_DATA_O     <= 8'h00;
      rx_shift      <= 8'h00;
    end else begin
      RX_CRC_FAIL_O <= rx_fail;
      RX_VALID_O    <= 1'b0;
      if (link.b_strobe) begin
        rx_shift <= {rx_shift[6:0], link.b_data};
        if (rx_bit == 8'h02 && rx_frm[0]) begin
          RX_ALARM_O <= link.b_data;
        end
        // Taken regardless of this half's own check
        if (rx_bit == 8'h00 && rx_frm == 4'hD) begin
          RX_E_BITS_O[1] <= link.b_data;
        end
        if (rx_bit == 8'h00 && rx_frm == 4'hF) begin
          RX_E_BITS_O[0] <= link.b_data;
        end
        if (rx_bit[2:0] == 3'h7 && rx_bit[7:3] != 5'h00) begin
          RX_VALID_O <= 1'b1;
          RX_DATA_O  <= {rx_shift[6:0], link.b_data};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Outgoing E bits: one zero per faulty half, next multiframe
  // ---------------------------------------------------------------
  // Loaded as frame 0 bit 1 goes out; receive lags transmit by a clock,
  // so a fault found at the end of the last multiframe still makes it
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      e_pend <= 2'h3;
      e_out  <= 2'h3;
    end else begin
      if (bit_stb && tx_bit == 8'h00 && tx_frm == 4'h0) begin
        e_out  <= e_pend;
        e_pend <= rx_fail ? 2'h1 : 2'h3;
      end else if (rx_fail) begin
        // A second fault before reload uses the other bit
        e_pend <= e_pend[1] ? {1'b0, e_pend[0]} : 2'h0;
      end
    end
  end
endmodule

//--- hdl/tsf_defs.svh
/*
  Timing and field constants for the time-slot-0 framer.
  Assumes inclusion by bare name from any design file.
*/
`ifndef TSF_DEFS_SVH
`define TSF_DEFS_SVH
`define TSF_FRAME_BITS    256
`define TSF_FRAMES_MF     16
`define TSF_FRAMES_HALF   8
`define TSF_BIT_RATE_HZ   2048000
`define TSF_FRAME_RATE_HZ 8000
`define TSF_CLK_HZ        20000000
`define TSF_BIT_CYCLES    (`TSF_CLK_HZ / `TSF_BIT_RATE_HZ)
`define TSF_ALIGN_WORD    7'h1B
`define TSF_MF_PATTERN    6'h0B
`define TSF_CRC_POLY      4'h3
`define TSF_SPARE_ONES    5'h1F
`define TSF_FIFO_DEPTH    16
`endif

//--- hdl/tsf_pkg.sv
/*
  Types shared by both framer ends.
  Assumes tsf_defs.svh is reachable on the include path.
*/
package tsf_pkg;
  typedef logic [7:0] tsf_bit_idx_t;
  typedef logic [3:0] tsf_frame_idx_t;
  typedef logic [3:0] tsf_crc_t;
  typedef logic [7:0] tsf_octet_t;

  // Next CRC remainder after shifting in one bit, MSB first
  // Bit enters at the top, so the x^4 factor needs no extra flush
  function automatic tsf_crc_t tsf_crc_step(input tsf_crc_t r, input logic b);
    logic fb;
    fb = r[3] ^ b;
    tsf_crc_step = {r[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
  endfunction
endpackage

//--- hdl/tsf_link_if.sv
/*
  Serial link between two framer ends, one line bit a strobe.
  Assumes both ends share REF_CLK_I.
*/
`timescale 1ns/10ps
interface tsf_link_if;
  logic a_data;
  logic a_strobe;
  logic b_data;
  logic b_strobe;
  modport near_end (output a_data, output a_strobe, input b_data, input b_strobe);
  modport far_end  (input a_data, input a_strobe, output b_data, output b_strobe);
endinterface

//--- hdl/tsf_fifo.sv
/*
  Parameterised valid/ready FIFO for payload octets.
  Assumes a single clock and active-low async reset.
*/
`timescale 1ns/10ps
module tsf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign in_ready_o  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

//--- hdl/tsf_peer.sv
/*
  Far end of the link: a framer instance adapted to the far modport.
  Assumes the near end drives a_* and reads b_*.
*/
`timescale 1ns/10ps
module tsf_peer (
  // Clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                NRST_I,
  // Link
  tsf_link_if.far_end              link,
  // Payload in
  input  wire logic                TX_VALID_I,
  output logic                     TX_READY_O,
  input  wire tsf_pkg::tsf_octet_t TX_DATA_I,
  // Control
  input  wire logic                ALARM_I,
  // Payload out and status
  output logic                     RX_VALID_O,
  output tsf_pkg::tsf_octet_t      RX_DATA_O,
  output logic                     RX_ALARM_O,
  output logic [1:0]               RX_E_BITS_O,
  output logic                     RX_CRC_FAIL_O
);
  import tsf_pkg::*;
  // Same framer, crossed wiring through a local link
  tsf_link_if x ();
  assign x.b_data     = link.a_data;
  assign x.b_strobe   = link.a_strobe;
  assign link.b_data   = x.a_data;
  assign link.b_strobe = x.a_strobe;

  tsf_framer u_fr (
    .REF_CLK_I     (REF_CLK_I),
    .NRST_I        (NRST_I),
    .link          (x.near_end),
    .TX_VALID_I    (TX_VALID_I),
    .TX_READY_O    (TX_READY_O),
    .TX_DATA_I     (TX_DATA_I),
    .ALARM_I       (ALARM_I),
    .RX_VALID_O    (RX_VALID_O),
    .RX_DATA_O     (RX_DATA_O),
    .RX_ALARM_O    (RX_ALARM_O),
    .RX_E_BITS_O   (RX_E_BITS_O),
    .RX_CRC_FAIL_O (RX_CRC_FAIL_O)
  );
endmodule

//--- test/tsf_link_checker.sv
/*
  Link checker: bit timing, slot-0 overhead and check bits on a clean link.
  Assumes both ends aligned from reset; sits beside the fault-free link.
*/
`timescale 1ns/10ps
module tsf_link_checker (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // Link
  input wire logic a_data,
  input wire logic a_strobe,
  input wire logic b_data,
  input wire logic b_strobe
);
  localparam logic [6:0] ALIGN = 7'h1B;
  localparam logic [5:0] MFA   = 6'h0B;
  logic [7:0] pos;
  logic [3:0] frm;
  logic [3:0] crc;
  logic [3:0] prev;
  logic       have;
  logic       din;

  // Own copy of the division, so a shared slip cannot hide
  function automatic logic [3:0] div_step(input logic [3:0] r, input logic b);
    div_step = {r[2:0], 1'b0} ^ ((r[3] ^ b) ? 4'h3 : 4'h0);
  endfunction

  // ----------------------------------------
  // Position and remainder of the near line
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pos <= 8'h00;
      frm <= 4'h0;
    end else if (a_strobe) begin
      pos <= pos + 8'h01;
      frm <= (pos == 8'hFF) ? frm + 4'h1 : frm;
    end
  end

  assign din = (pos == 8'h00 && !frm[0]) ? 1'b0 : a_data;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      crc  <= 4'h0;
      prev <= 4'h0;
      have <= 1'b0;
    end else if (a_strobe && pos == 8'hFF && frm[2:0] == 3'h7) begin
      prev <= div_step(crc, din);
      crc  <= 4'h0;
      have <= 1'b1;
    end else if (a_strobe) begin
      crc <= div_step(crc, din);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  sequence a_gap_s;
    !a_strobe [*8] ##1 a_strobe;
  endsequence
  sequence b_gap_s;
    !b_strobe [*8] ##1 b_strobe;
  endsequence

  near_bit_rate_a: assert property (a_strobe |=> a_gap_s)
    else $error("near strobe spacing wrong");
  far_bit_rate_a: assert property (b_strobe |=> b_gap_s)
    else $error("far strobe spacing wrong");
  align_word_a: assert property (
    a_strobe && !frm[0] && pos inside {[8'h01:8'h07]} |-> a_data == ALIGN[3'(8'h07 - pos)])
    else $error("alignment word bit wrong");
  odd_bit_two_a: assert property (a_strobe && frm[0] && pos == 8'h01 |-> a_data)
    else $error("bit 2 of odd frame not one");
  spare_ones_a: assert property (
    a_strobe && frm[0] && pos inside {[8'h03:8'h07]} |-> a_data)
    else $error("spare bit not one");
  mf_align_a: assert property (
    a_strobe && frm[0] && pos == 8'h00 && frm < 4'hC |-> a_data == MFA[3'(3'h5 - frm[3:1])])
    else $error("multiframe pattern bit wrong");
  check_bits_a: assert property (
    a_strobe && have && !frm[0] && pos == 8'h00 |-> a_data == prev[2'(2'h3 - frm[2:1])])
    else $error("check bit wrong");
  clean_e_bits_a: assert property (
    a_strobe && pos == 8'h00 && (frm == 4'hD || frm == 4'hF) |-> a_data)
    else $error("error bit cleared on clean link");
endmodule

//--- test/tb.sv
/*
  Testbench: two end tops face each other over crossed links; a third
  hears a copy of the near line with two bits broken.
  Assumes the design files and their include file are on the compile path.
*/
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module tb;
  import tsf_pkg::*;
  logic       clk, nrst, flip;
  logic       f_valid, f_ready, f_alarm, f_rx_valid, f_rx_alarm, f_fail;
  logic       p_valid, p_ready, p_alarm, p_rx_valid, p_rx_alarm, p_fail, g_fail;
  tsf_octet_t f_data, f_rx_data, p_data, p_rx_data, a_oct, b_oct;
  logic [1:0] f_e, p_e, g_e, e_seen;
  logic [7:0] bpos;
  logic [3:0] bfrm, mf;
  int         i, k, f_took, p_took, g_fails, clean_fails, e_zeros, n_fail, tests_run;

  tsf_link_if link ();
  tsf_link_if link_n ();
  tsf_link_if link2 ();
  // Near end is an end top whose link is crossed back onto the near line
  assign link.a_data     = link_n.b_data;
  assign link.a_strobe   = link_n.b_strobe;
  assign link_n.a_data   = link.b_data;
  assign link_n.a_strobe = link.b_strobe;
  tsf_peer tsf_peer_i2 (.REF_CLK_I(clk), .NRST_I(nrst), .link(link_n), .TX_VALID_I(f_valid),
    .TX_READY_O(f_ready), .TX_DATA_I(f_data), .ALARM_I(f_alarm), .RX_VALID_O(f_rx_valid),
    .RX_DATA_O(f_rx_data), .RX_ALARM_O(f_rx_alarm), .RX_E_BITS_O(f_e), .RX_CRC_FAIL_O(f_fail));
  tsf_peer tsf_peer_i (.REF_CLK_I(clk), .NRST_I(nrst), .link(link), .TX_VALID_I(p_valid),
    .TX_READY_O(p_ready), .TX_DATA_I(p_data), .ALARM_I(p_alarm), .RX_VALID_O(p_rx_valid),
    .RX_DATA_O(p_rx_data), .RX_ALARM_O(p_rx_alarm), .RX_E_BITS_O(p_e), .RX_CRC_FAIL_O(p_fail));
  tsf_peer tsf_peer_i3 (.REF_CLK_I(clk), .NRST_I(nrst), .link(link2), .TX_VALID_I(1'b0),
    .TX_READY_O(), .TX_DATA_I(8'h00), .ALARM_I(1'b0), .RX_VALID_O(), .RX_DATA_O(),
    .RX_ALARM_O(), .RX_E_BITS_O(g_e), .RX_CRC_FAIL_O(g_fail));
  tsf_link_checker tsf_link_checker_i (.REF_CLK_I(clk), .NRST_I(nrst), .a_data(link.a_data),
    .a_strobe(link.a_strobe), .b_data(link.b_data), .b_strobe(link.b_strobe));

  // ----------------------------------------
  // Broken copy of the near line and line monitors
  // ----------------------------------------
  // One payload bit in half I and one E bit in half II of multiframe 0
  assign flip = (mf == 4'h0 && bfrm == 4'hD && bpos == 8'h00) ||
                (mf == 4'h0 && bfrm == 4'h1 && bpos == 8'h14);
  assign link2.a_strobe = link.a_strobe;
  assign link2.a_data = link.a_data ^ flip;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bpos <= 8'h00;
      bfrm <= 4'h0;
      mf   <= 4'h0;
    end else if (link.a_strobe) begin
      bpos <= bpos + 8'h01;
      bfrm <= (bpos == 8'hFF) ? bfrm + 4'h1 : bfrm;
      mf   <= (bpos == 8'hFF && bfrm == 4'hF) ? mf + 4'h1 : mf;
    end
  end

  always @(posedge clk) begin
    if (g_fail === 1'b1) g_fails++;
    if (f_fail === 1'b1 || p_fail === 1'b1) clean_fails++;
    // Pushes counted at the edge that takes them
    if (f_valid === 1'b1 && f_ready === 1'b1) f_took++;
    if (p_valid === 1'b1 && p_ready === 1'b1) p_took++;
    // First fault reaches the line in multiframe 1, the second only in 2
    if (link2.b_strobe === 1'b1 && bpos == 8'h00 && (bfrm == 4'hD || bfrm == 4'hF) &&
        mf == 4'h1 && link2.b_data === 1'b0) e_zeros++;
    if (link.a_strobe === 1'b1 && mf == 4'h0 && bfrm == 4'hE && bpos == 8'h00) e_seen = g_e;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic timed_out(input string what);
    n_fail++;
    $display("ERROR %s expected done seen timeout", what);
    final_report();
  endtask

  // Both ends are aligned, so their octets arrive in the same cycle
  task automatic pull(output tsf_octet_t far_oct, output tsf_octet_t near_oct);
    int n;
    for (n = 0; n < 200 && p_rx_valid !== 1'b1; n++)
      @(posedge clk);
    if (n == 200) timed_out("rx octet");
    far_oct = p_rx_data;
    near_oct = f_rx_data;
    @(posedge clk);
  endtask

  task automatic wait_alarm(input logic v);
    int n;
    for (n = 0; n < 5000 && !(p_rx_alarm === v && f_rx_alarm === v); n++)
      @(posedge clk);
    if (n == 5000) timed_out("alarm");
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {nrst, f_valid, f_alarm, p_valid, p_alarm} = 5'h00;
    {f_data, p_data} = 16'h0000;
    repeat (4) @(posedge clk);
    `CHECK("idle line", 1'b1, link.a_data)
    `CHECK("reset e bits", 2'b11, f_e)
    `CHECK("reset fail", 1'b0, f_fail)
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 20; i++) begin
      f_valid <= 1'b1;
      f_data <= 8'(i + 1);
      p_valid <= 1'b1;
      p_data <= 8'(8'h80 + i);
      @(posedge clk);
    end
    f_valid <= 1'b0;
    p_valid <= 1'b0;
    `CHECK("near fifo depth", 16, f_took)
    `CHECK("far fifo depth", 16, p_took)
    for (i = 1; i <= 17; i++) begin
      pull(a_oct, b_oct);
      `CHECK("far rx octet", (i < 17) ? 8'(i) : 8'hFF, a_oct)
      `CHECK("near rx octet", (i < 17) ? 8'(8'h7F + i) : 8'hFF, b_oct)
    end
    $display("test payload done");
    `CHECK("alarm idle", 1'b0, p_rx_alarm)
    f_alarm <= 1'b1;
    p_alarm <= 1'b1;
    wait_alarm(1'b1);
    `CHECK("far alarm", 1'b1, p_rx_alarm)
    `CHECK("near alarm", 1'b1, f_rx_alarm)
    f_alarm <= 1'b0;
    p_alarm <= 1'b0;
    wait_alarm(1'b0);
    `CHECK("far alarm clear", 1'b0, p_rx_alarm)
    $display("test alarm done");
    for (k = 0; k < 80000 && mf != 4'h2; k++)
      @(posedge clk);
    if (k == 80000) timed_out("multiframes");
    `CHECK("faulty halves", 2, g_fails)
    `CHECK("cleared e bits", 1, e_zeros)
    `CHECK("e bits from faulty half", 2'b01, e_seen)
    `CHECK("clean link faults", 0, clean_fails)
    `CHECK("near e bits", 2'b11, f_e)
    `CHECK("far e bits", 2'b11, p_e)
    $display("test check blocks done");
    final_report();
  end
endmodule
